// [src/prm_pkg.sv]
// Purpose: shared constants and types for the ratio and output control block
// Assumes: classic wishbone slave, 32-bit data, word addressed registers
// Notes: register byte address is four times the register index
package prm_pkg;
   // register indices (byte address = index * 4)
   localparam logic [7:0] PRM_IDX_RATIO = 8'h06;
   localparam logic [7:0] PRM_IDX_CTRL = 8'h10;
   localparam logic [7:0] PRM_IDX_STAT = 8'h11;
   localparam logic [7:0] PRM_IDX_EFF = 8'h12;
   // control field positions
   localparam int PRM_CTL_BW_LO = 0;
   localparam int PRM_CTL_FMT = 4;
   localparam int PRM_CTL_SCL_LO = 8;
   localparam int PRM_CTL_OFF = 12;
   localparam int PRM_CTL_RUN = 13;
   // reset values
   localparam logic [31:0] PRM_RATIO_RST = 32'h0000_0000;
   localparam logic [2:0] PRM_BW_RST = 3'h0;
   localparam logic PRM_FMT_RST = 1'b0; // 0 = 20.12, 1 = 12.20
   localparam logic [2:0] PRM_SCL_RST = 3'h0;
   // fraction widths of the two formats
   localparam int PRM_FRAC_HIRES = 20;
   localparam int PRM_FRAC_HIMUL = 12;
   // loop bandwidth code used during lock acquisition
   localparam logic [3:0] PRM_BW_WIDE = 4'h8;
   // timing: relock time after a ratio change
   localparam int PRM_RELOCK_NS = 1000;
   localparam int PRM_CLK_NS = 5;
   localparam int PRM_RELOCK_CYC = PRM_RELOCK_NS / PRM_CLK_NS;
   // control bits as carried together
   typedef struct packed {
      logic run_unl;
      logic off;
      logic [2:0] scale;
      logic fmt;
      logic [2:0] bw;
   } prm_ctrl_s;
   typedef enum logic [1:0] {PRM_ST_ACQ, PRM_ST_LOCK} prm_lock_e;
endpackage

// [src/prm_ratio_calc.sv]
// Purpose: effective ratio = user ratio times modifier, normalised to 20.20
// Assumes: misuse that overflows the format is avoided by software
// Notes: combinational; stored ratio is never touched
`timescale 1ns/100ps
`default_nettype none
module prm_ratio_calc
(
   // inputs
   input wire logic [31:0] ratio_i,
   input wire logic fmt_i,
   input wire logic [2:0] scale_i,
   // result in 20.20 fixed point
   output logic [39:0] eff_o
);
   import prm_pkg::*;
   logic [47:0] norm;
   // bring both formats to 20 fraction bits, then shift by the modifier
   always_comb
   begin
      norm = fmt_i ? {16'h0000, ratio_i} : {8'h00, ratio_i, 8'h00};
      if (scale_i[2])
         norm = norm >> ({2'b00, scale_i[1:0]} + 4'h1);
      else
         norm = norm << scale_i[1:0];
      eff_o = norm[39:0];
   end
endmodule
`default_nettype wire

// [src/prm_ctrl.sv]
// Purpose: ratio, bandwidth and clock output control of the multiplier
// Assumes: synthesizer clock and lock come from the analog side as inputs
// Notes: wishbone classic slave, ack one cycle after strobe
`timescale 1ns/100ps
`default_nettype none
module prm_ctrl
#(
   parameter int RELOCK_CYC = prm_pkg::PRM_RELOCK_CYC,
   parameter int REFDIV_W = 2
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // synthesizer side
   input wire logic synth_clk_i,
   input wire logic loop_locked_i,
   input wire logic [REFDIV_W-1:0] ref_div_i,
   output logic [3:0] loop_bw_o,
   output logic [39:0] effective_ratio_o,
   output logic relock_o,
   // clock output pin
   output logic clk_out_o,
   output logic clk_out_oe_n_o
);
   import prm_pkg::*;
   // relock counter is 16 bits wide; divider selects wider than 4 bits are not served
   if (RELOCK_CYC < 1 || RELOCK_CYC > 65535 || REFDIV_W < 1 || REFDIV_W > 4)
   begin : g_param_check
      $error("prm_ctrl: bad parameter");
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   logic [31:0] ratio_reg, ratio_next;
   prm_ctrl_s ctrl_reg, ctrl_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   prm_lock_e st_reg, st_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [39:0] eff_raw;
   logic [39:0] eff_reg, eff_next;
   logic wr, frac_change;
   logic [7:0] idx;
   logic [31:0] ctrl_word;
   logic [31:0] ctrl_m;

   prm_ratio_calc u_calc
   (
      .ratio_i(ratio_reg),
      .fmt_i(ctrl_reg.fmt),
      .scale_i(ctrl_reg.scale),
      .eff_o(eff_raw)
   );

   assign idx = adr_i[9:2];
   assign wr = cyc_i && stb_i && we_i && !ack_reg;
   assign ctrl_word = {18'h0, ctrl_reg.run_unl, ctrl_reg.off, 1'b0, ctrl_reg.scale,
                       3'h0, ctrl_reg.fmt, 1'b0, ctrl_reg.bw};

   // register file and bus answer
   always_comb
   begin
      ratio_next = ratio_reg;
      ctrl_next = ctrl_reg;
      ack_next = cyc_i && stb_i && !ack_reg;
      dat_next = 32'h0000_0000;
      frac_change = 1'b0;
      // byte lanes merged over the current control word
      ctrl_m = merge(ctrl_word, dat_i, sel_i);
      if (wr && idx == PRM_IDX_RATIO)
      begin
         ratio_next = merge(ratio_reg, dat_i, sel_i);
      end
      if (wr && idx == PRM_IDX_CTRL)
      begin
         ctrl_next.bw = ctrl_m[PRM_CTL_BW_LO +: 3];
         ctrl_next.fmt = ctrl_m[PRM_CTL_FMT];
         ctrl_next.scale = ctrl_m[PRM_CTL_SCL_LO +: 3];
         ctrl_next.off = ctrl_m[PRM_CTL_OFF];
         ctrl_next.run_unl = ctrl_m[PRM_CTL_RUN];
      end
      frac_change = (ratio_next != ratio_reg) || (ctrl_next.fmt != ctrl_reg.fmt) ||
                    (ctrl_next.scale != ctrl_reg.scale);
      if (cyc_i && stb_i && !we_i && !ack_reg)
      begin
         unique case (idx)
            PRM_IDX_RATIO: dat_next = ratio_reg;
            PRM_IDX_CTRL: dat_next = ctrl_word;
            PRM_IDX_STAT: dat_next = {27'h0, st_reg == PRM_ST_LOCK, loop_bw_o};
            PRM_IDX_EFF: dat_next = eff_reg[39:8];
            default: dat_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ratio_reg <= PRM_RATIO_RST;
         ctrl_reg <= '{run_unl: 1'b0, off: 1'b0, scale: PRM_SCL_RST, fmt: PRM_FMT_RST,
                       bw: PRM_BW_RST};
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end
      else
      begin
         ratio_reg <= ratio_next;
         ctrl_reg <= ctrl_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = dat_reg;

   // lock tracking: acquire after reset or any fractional change
   always_comb
   begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      eff_next = eff_raw >> ref_div_i;
      unique case (st_reg)
         PRM_ST_ACQ:
         begin
            if (cnt_reg != 16'h0)
               cnt_next = cnt_reg - 16'h1;
            else if (loop_locked_i)
               st_next = PRM_ST_LOCK;
         end
         PRM_ST_LOCK:
         begin
            if (!loop_locked_i)
               st_next = PRM_ST_ACQ;
         end
         default: st_next = PRM_ST_ACQ;
      endcase
      if (frac_change)
      begin
         st_next = PRM_ST_ACQ;
         cnt_next = 16'(RELOCK_CYC);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= PRM_ST_ACQ;
         cnt_reg <= 16'h0;
         eff_reg <= 40'h0;
      end
      else
      begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         eff_reg <= eff_next;
      end
   end

   assign effective_ratio_o = eff_reg;
   assign relock_o = st_reg == PRM_ST_ACQ;
   assign loop_bw_o = relock_o ? PRM_BW_WIDE : {1'b0, ctrl_reg.bw};
   // low when unlocked, run_unl overrides; synth_clk_i is gated by a plain AND
   assign clk_out_o = synth_clk_i & (!relock_o | ctrl_reg.run_unl);
   assign clk_out_oe_n_o = ctrl_reg.off;

   property p_wide_acq;
      @(posedge clk_i) disable iff (rst_i) relock_o |-> loop_bw_o == PRM_BW_WIDE;
   endproperty
   a_wide_acq: assert property (p_wide_acq) else $error("bw not wide");
   property p_bw_lock;
      @(posedge clk_i) disable iff (rst_i) !relock_o |-> loop_bw_o == {1'b0, ctrl_reg.bw};
   endproperty
   a_bw_lock: assert property (p_bw_lock) else $error("bw not selected");
   property p_relock;
      @(posedge clk_i) disable iff (rst_i) frac_change |=> relock_o [*2];
   endproperty
   a_relock: assert property (p_relock) else $error("no relock");
   property p_low;
      @(posedge clk_i) disable iff (rst_i) relock_o && !ctrl_reg.run_unl |-> !clk_out_o;
   endproperty
   a_low: assert property (p_low) else $error("clk not low");
   property p_run;
      @(posedge clk_i) disable iff (rst_i)
         ctrl_reg.run_unl |-> clk_out_o == synth_clk_i;
   endproperty
   a_run: assert property (p_run) else $error("clk not passed");
   property p_off;
      @(posedge clk_i) disable iff (rst_i) ctrl_reg.off |-> clk_out_oe_n_o;
   endproperty
   a_off: assert property (p_off) else $error("driver on");
   property p_keep;
      @(posedge clk_i) disable iff (rst_i)
         !(wr && idx == PRM_IDX_RATIO) |=> ratio_reg == $past(ratio_reg);
   endproperty
   a_keep: assert property (p_keep) else $error("ratio changed");
   property p_unit;
      @(posedge clk_i) disable iff (rst_i)
         ctrl_reg.scale == 3'h0 && ctrl_reg.fmt |-> eff_raw == {8'h00, ratio_reg};
   endproperty
   a_unit: assert property (p_unit) else $error("unit scale wrong");
   property p_fmt;
      @(posedge clk_i) disable iff (rst_i)
         ctrl_reg.scale == 3'h0 && !ctrl_reg.fmt |-> eff_raw[39:8] == ratio_reg;
   endproperty
   a_fmt: assert property (p_fmt) else $error("20.12 wrong");
   property p_ack;
      @(posedge clk_i) disable iff (rst_i) cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_ack_once;
      @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held too long");
   // acquisition holds while the relock counter runs
   property p_acq_hold;
      @(posedge clk_i) disable iff (rst_i) relock_o && cnt_reg != 16'h0 |=> relock_o;
   endproperty
   a_acq_hold: assert property (p_acq_hold) else $error("left acquire early");
   // counter spent and loop locked: leave acquisition next edge
   property p_leave;
      @(posedge clk_i) disable iff (rst_i)
         relock_o && cnt_reg == 16'h0 && loop_locked_i && !frac_change |=> !relock_o;
   endproperty
   a_leave: assert property (p_leave) else $error("lock not taken");
   property p_ratio_wr;
      @(posedge clk_i) disable iff (rst_i)
         wr && idx == PRM_IDX_RATIO && sel_i == 4'hf |=> ratio_reg == $past(dat_i);
   endproperty
   a_ratio_wr: assert property (p_ratio_wr) else $error("ratio write lost");
   // with no divider the synthesizer sees the plain product
   property p_nodiv;
      @(posedge clk_i) disable iff (rst_i)
         ref_div_i == '0 |=> effective_ratio_o == $past(eff_raw);
   endproperty
   a_nodiv: assert property (p_nodiv) else $error("eff not passed");
   property p_half;
      @(posedge clk_i) disable iff (rst_i)
         ctrl_reg.scale == 3'h4 && ctrl_reg.fmt |-> eff_raw == {9'h000, ratio_reg[31:1]};
   endproperty
   a_half: assert property (p_half) else $error("half scale wrong");
   property p_oe_on;
      @(posedge clk_i) disable iff (rst_i) !ctrl_reg.off |-> !clk_out_oe_n_o;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("driver off");
   // main scenarios: lock, ratio write, unlock with run bit, lock loss, divide by 16 while locked
   c_drop: cover property (@(posedge clk_i) disable iff (rst_i) !relock_o ##1 relock_o);
   c_div16: cover property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg.scale == 3'h7 && !relock_o);
   c_lock: cover property (@(posedge clk_i) disable iff (rst_i) relock_o ##1 !relock_o);
   c_wr: cover property (@(posedge clk_i) disable iff (rst_i) wr && idx == PRM_IDX_RATIO);
   c_run: cover property (@(posedge clk_i) disable iff (rst_i) relock_o && ctrl_reg.run_unl);
endmodule
`default_nettype wire

// [sim/prm_synth_model.sv]
// Purpose: loop and synthesizer stand-in
// Assumes: lock comes DLY cycles into acquiring
// Notes: drop_i forces loss of lock
`timescale 1ns/100ps
`default_nettype none
module prm_synth_model
#(
   parameter int DLY = 3
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // loop side
   input wire logic relock_i,
   input wire logic drop_i,
   output logic synth_clk_o,
   output logic locked_o
);
   int cnt_reg;
   int cnt_next;
   logic lk_next;
   // lock only after a real acquire time
   always_comb
   begin
      cnt_next = relock_i ? cnt_reg + 1 : 0;
      lk_next = !drop_i && (!relock_i || cnt_reg >= DLY);
   end
   // synth clock toggles every cycle
   always_ff @(posedge clk_i)
   begin
      cnt_reg <= rst_i ? 0 : cnt_next;
      locked_o <= rst_i ? 1'h0 : lk_next;
      synth_clk_o <= rst_i ? 1'h0 : ~synth_clk_o;
   end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Purpose: register and output checks
// Assumes: ack comes well inside the watchdog span
// Notes: relock count shortened to 4
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import prm_pkg::*;
   // low nibble clear so a divide by 16 loses no bits in either format
   localparam logic [31:0] R_USER = 32'h0001_2340;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic drop = 1'h0;
   logic [1:0] rdiv = 2'h0;
   logic [9:0] adr = 10'h000;
   logic [31:0] wd = 32'h0;
   logic [31:0] rd;
   logic [39:0] e;
   int miscompares = 0;
   int cmp_count = 0;
   int f;
   int s;
   wire logic [31:0] dat_o;
   wire logic [39:0] eff;
   wire logic [3:0] bw;
   wire logic ack_o, sclk, lkd, relock, ck_o, oe_n;
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   prm_ctrl #(.RELOCK_CYC(4)) prm_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(dat_o),
      .ack_o(ack_o), .synth_clk_i(sclk), .loop_locked_i(lkd), .ref_div_i(rdiv),
      .loop_bw_o(bw), .effective_ratio_o(eff), .relock_o(relock), .clk_out_o(ck_o),
      .clk_out_oe_n_o(oe_n));
   prm_synth_model prm_synth_model_i (.clk_i(clk_i), .rst_i(rst_i), .relock_i(relock),
      .drop_i(drop), .synth_clk_o(sclk), .locked_o(lkd));
   task automatic conclude;
      $display("checks %0d errors %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [39:0] x, input logic [39:0] g);
      cmp_count++;
      if (g !== x)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   // classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {i, 2'h0};
      wd <= d;
      @(posedge clk_i);
      // no cycle count assumed; only the watchdog ends a hung wait
      while (ack_o !== 1'h1)
         @(posedge clk_i);
      rd = dat_o;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask
   task automatic wait_rl(input logic v);
      @(posedge clk_i);
      #1;
      while (relock !== v)
      begin
         @(posedge clk_i);
         #1;
      end
   endtask
   task automatic ck2(input logic gated);
      repeat (2)
      begin
         @(posedge clk_i);
         #1;
         chk("clk_out", gated ? 1'h0 : sclk, ck_o);
      end
   endtask
   function automatic logic [39:0] eff_of(input logic [31:0] r, input logic fm,
      input logic [2:0] sc, input int d);
      logic [39:0] x;
      x = fm ? {8'h00, r} : {r, 8'h00};
      x = sc[2] ? x >> (sc[1:0] + 3'h1) : x << sc[1:0];
      return x >> d;
   endfunction
   // watchdog, well past the expected run
   initial
   begin
      #100000;
      miscompares++;
      conclude();
   end
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      #1;
      chk("relock", 1, relock);
      chk("bw", 8, bw);
      chk("clk_out", 0, ck_o);
      chk("oe_n", 0, oe_n);
      wb(0, PRM_IDX_CTRL, 0);
      chk("ctrl", 0, rd);
      wb(1, PRM_IDX_RATIO, 32'hfedc_ba98);
      wb(0, PRM_IDX_RATIO, 0);
      chk("ratio", 32'hfedc_ba98, rd);
      wb(1, 8'h20, 32'h1);
      wb(0, 8'h20, 0);
      chk("unmapped", 0, rd);
      wb(1, PRM_IDX_CTRL, 32'h710);
      wb(1, PRM_IDX_RATIO, R_USER);
      for (f = 0; f < 2; f++)
         for (s = 0; s < 8; s++)
         begin
            wb(1, PRM_IDX_CTRL, 32'((f << PRM_CTL_FMT) | (s << PRM_CTL_SCL_LO)));
            @(posedge clk_i);
            #1;
            chk("relock", 1, relock);
            chk("wide", 8, bw);
            wait_rl(0);
            e = eff_of(R_USER, f[0], s[2:0], 0);
            chk("eff", e, eff);
            wb(0, PRM_IDX_EFF, 0);
            chk("eff_reg", e[39:8], rd);
            wb(0, PRM_IDX_RATIO, 0);
            chk("ratio", R_USER, rd);
         end
      for (s = 0; s < 8; s++)
      begin
         wb(1, PRM_IDX_CTRL, 32'(s));
         wait_rl(0);
         chk("bw_min", 40'(s), bw);
      end
      wb(0, PRM_IDX_STAT, 0);
      chk("stat", 32'h17, rd);
      ck2(0);
      @(posedge clk_i);
      drop <= 1'h1;
      wait_rl(1);
      ck2(1);
      // second reset in mid-run while lock is still lost
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      #1;
      chk("relock", 1, relock);
      chk("oe_n", 0, oe_n);
      wb(0, PRM_IDX_RATIO, 0);
      chk("ratio_rst", PRM_RATIO_RST, rd);
      // run bit set before any ratio runs, never toggled later
      wb(1, PRM_IDX_CTRL, 32'h2007);
      wb(1, PRM_IDX_RATIO, R_USER);
      ck2(0);
      @(posedge clk_i);
      drop <= 1'h0;
      wait_rl(0);
      wb(1, PRM_IDX_CTRL, 32'h3007);
      @(posedge clk_i);
      #1;
      chk("oe_n", 1, oe_n);
      @(posedge clk_i);
      rdiv <= 2'h1;
      repeat (3) @(posedge clk_i);
      #1;
      chk("eff_div", eff_of(R_USER, 1'h0, 3'h0, 1), eff);
      conclude();
   end
endmodule
`default_nettype wire
